// ---- common/gbsp_defs.vh ----
// Constants for the pin port: register offsets, fields, resets, timing.
// Assumes inclusion by the port top module, the monitor and the bench top; definitions only.
`ifndef GBSP_DEFS_VH
`define GBSP_DEFS_VH

// Register indices on the plain port (byte-free word addresses).
`define GBSP_ADDR_W         4
`define GBSP_REG_DIR        4'h0
`define GBSP_REG_OUT        4'h1
`define GBSP_REG_IRQ_EN     4'h2
`define GBSP_REG_EDGE       4'h3
`define GBSP_REG_FLAG       4'h4
`define GBSP_REG_IN         4'h5
`define GBSP_REG_STAT1      4'h6
`define GBSP_REG_PWRSEL     4'h7
`define GBSP_REG_CARDCTL    4'h8

// Pin numbers inside the pin vector.
`define GBSP_NPINS          11
`define GBSP_PIN_BOOT       6
`define GBSP_PIN_PWR_A      8
`define GBSP_PIN_PWR_B      10

// Fields of the status register.
`define GBSP_STAT_BOOT_BIT  0

// Fields of the power select register.
`define GBSP_PWR_SEL_A      0
`define GBSP_PWR_SEL_B      1
`define GBSP_PWR_ON_A       2
`define GBSP_PWR_ON_B       3

// Fields of the card control register.
`define GBSP_CC_CMD_PU      0
`define GBSP_CC_WP_PD       1
`define GBSP_CC_CMD_OE      2
`define GBSP_CC_CMD_OUT     3

// Reset values.
`define GBSP_RST_PINS       11'h000
`define GBSP_RST_CARDCTL    4'h3
`define GBSP_RST_PWR        4'h0

// Pull-up release point after reset negation, in cycles of the counter; the pull-up drops one cycle later.
`define GBSP_PU_HOLD_CYC    8

// Strap capture point after reset negation, in cycles of the counter.
`define GBSP_STRAP_SAMPLE_CYC 2

`endif

// ---- verilog/gbsp_sync2.v ----
// Two-stage synchroniser for a vector of asynchronous pin levels.
// Assumes a single clock domain and an active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module gbsp_sync2 #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         arst_n,
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);
   reg [W-1:0] meta_q;

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= {W{1'b0}};
         q      <= {W{1'b0}};
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule // gbsp_sync2
`default_nettype wire

// ---- verilog/gbsp_edge_det.v ----
// Per-pin edge detector with selectable polarity and sticky flags.
// Assumes synchronised inputs; clear mask is a one-cycle pulse.
`timescale 1ns/1ns
`default_nettype none
module gbsp_edge_det #(
   parameter N = 11
) (
   input  wire         clk,
   input  wire         arst_n,
   input  wire [N-1:0] pin_in,
   input  wire [N-1:0] enable,
   input  wire [N-1:0] rising,
   input  wire [N-1:0] clear,
   output reg  [N-1:0] flag_q
);
   reg  [N-1:0] prev_q;
   wire [N-1:0] hit;

   genvar i;
   generate
      for (i = 0; i < N; i = i + 1) begin : g_pin
         // Rising or falling edge per pin, as software selects.
         assign hit[i] = enable[i] & (rising[i] ?
                         (pin_in[i] & ~prev_q[i]) :
                         (~pin_in[i] & prev_q[i]));
      end
   endgenerate

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prev_q <= {N{1'b0}};
         flag_q <= {N{1'b0}};
      end else begin
         prev_q <= pin_in;
         // A new edge wins over a clear in the same cycle.
         flag_q <= (flag_q & ~clear) | hit;
      end
   end
endmodule // gbsp_edge_det
`default_nettype wire

// ---- verilog/gbsp_port.v ----
// General purpose pin port with boot strap, card power and card pulls.
// Assumes pins arrive asynchronously; register port on the core clock.
//
// What this block does
// - Pins are input, edge interrupt or output.
// - Boot pin pull-up on during reset.
// - Pull-up released some cycles after reset.
// - Boot pin level captured two counter cycles after reset release.
// - Captured level readable in status register one.
// - Boot pin is ordinary pin once the pull-up is released.
// - Two pins switch to card power outputs.
// - Command line bidirectional with controlled pull-up.
// - Write-protect input has controlled pull-down.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "gbsp_defs.vh"
module gbsp_port #(
   parameter N = `GBSP_NPINS
) (
   input  wire                    clk,
   input  wire                    arst_n,
   input  wire [`GBSP_ADDR_W-1:0] reg_addr,
   input  wire [N-1:0]            reg_wdata,
   input  wire                    reg_wr,
   input  wire                    reg_rd,
   output reg  [N-1:0]            reg_rdata_q,
   input  wire [N-1:0]            pin_in,
   output reg  [N-1:0]            pin_out_q,
   output reg  [N-1:0]            pin_oe_q,
   output reg                     boot_pullup_en_q,
   output reg                     internal_code_select_flag_q,
   output reg                     pin_irq_q,
   output reg                     card_power_out_a_q,
   output reg                     card_power_out_b_q,
   input  wire                    card_command_line_in,
   output reg                     card_command_line_out_q,
   output reg                     card_command_line_oe_q,
   output reg                     card_command_pullup_en_q,
   input  wire                    card_write_protect_in,
   output reg                     card_write_protect_pd_en_q,
   output reg                     card_write_protect_q
);
   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.
   wire [N-1:0] pin_s;
   wire [1:0]   card_s;

   gbsp_sync2 #(.W(N)) u_sync_pins (
      .clk    (clk),
      .arst_n (arst_n),
      .d      (pin_in),
      .q      (pin_s)
   );

   gbsp_sync2 #(.W(2)) u_sync_card (
      .clk    (clk),
      .arst_n (arst_n),
      .d      ({card_write_protect_in, card_command_line_in}),
      .q      (card_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // Software registers.
   reg  [N-1:0] dir_q;
   reg  [N-1:0] out_q;
   reg  [N-1:0] irq_en_q;
   reg  [N-1:0] edge_q;
   reg  [3:0]   pwr_q;
   reg  [3:0]   cardctl_q;
   reg          cmd_in_q;
   wire [N-1:0] flag;
   wire [N-1:0] clr;
   wire         wr_dir;
   wire         wr_out;
   wire         wr_irq_en;
   wire         wr_edge;
   wire         wr_flag;
   wire         wr_pwr;
   wire         wr_cardctl;

   // One write strobe per writable register index.
   assign wr_dir     = reg_wr & (reg_addr == `GBSP_REG_DIR);
   assign wr_out     = reg_wr & (reg_addr == `GBSP_REG_OUT);
   assign wr_irq_en  = reg_wr & (reg_addr == `GBSP_REG_IRQ_EN);
   assign wr_edge    = reg_wr & (reg_addr == `GBSP_REG_EDGE);
   assign wr_flag    = reg_wr & (reg_addr == `GBSP_REG_FLAG);
   assign wr_pwr     = reg_wr & (reg_addr == `GBSP_REG_PWRSEL);
   assign wr_cardctl = reg_wr & (reg_addr == `GBSP_REG_CARDCTL);
   // Ones written to the flag index clear those flags.
   assign clr        = wr_flag ? reg_wdata : {N{1'b0}};

   // Direction per pin, a one drives the pin.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dir_q <= `GBSP_RST_PINS;
      end else if (wr_dir) begin
         dir_q <= reg_wdata;
      end
   end

   // Output level per pin.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         out_q <= `GBSP_RST_PINS;
      end else if (wr_out) begin
         out_q <= reg_wdata;
      end
   end

   // Interrupt enable per pin.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_en_q <= `GBSP_RST_PINS;
      end else if (wr_irq_en) begin
         irq_en_q <= reg_wdata;
      end
   end

   // Edge select per pin, a one picks the rising edge.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         edge_q <= `GBSP_RST_PINS;
      end else if (wr_edge) begin
         edge_q <= reg_wdata;
      end
   end

   // Card power select and power on bits.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pwr_q <= `GBSP_RST_PWR;
      end else if (wr_pwr) begin
         pwr_q <= reg_wdata[3:0];
      end
   end

   // Card line pulls and command line drive.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cardctl_q <= `GBSP_RST_CARDCTL;
      end else if (wr_cardctl) begin
         cardctl_q <= reg_wdata[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Edge-triggered interrupt inputs (inputs only).
   gbsp_edge_det #(.N(N)) u_edge (
      .clk    (clk),
      .arst_n (arst_n),
      .pin_in (pin_s),
      .enable (irq_en_q & ~dir_q),
      .rising (edge_q),
      .clear  (clr),
      .flag_q (flag)
   );

   ////////////////////////////////////////////////////////////////////////
   // Boot strap: pull-up held, level captured after release, pull-up off.
   reg  [3:0] hold_cnt_q;
   reg  [3:0] hold_cnt_d;
   reg        boot_done_q;
   reg        boot_done_d;
   reg        boot_pullup_en_d;
   reg        internal_code_select_flag_d;

   always @* begin
      hold_cnt_d                  = hold_cnt_q;
      boot_done_d                 = boot_done_q;
      boot_pullup_en_d            = boot_pullup_en_q;
      internal_code_select_flag_d = internal_code_select_flag_q;
      if (!boot_done_q) begin
         // The synchroniser resets to zero, so the pin is first seen here.
         if (hold_cnt_q == `GBSP_STRAP_SAMPLE_CYC) begin
            internal_code_select_flag_d = pin_s[`GBSP_PIN_BOOT];
         end
         if (hold_cnt_q == `GBSP_PU_HOLD_CYC) begin
            boot_pullup_en_d = 1'b0;
            boot_done_d      = 1'b1;
         end else begin
            hold_cnt_d = hold_cnt_q + 4'h1;
         end
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hold_cnt_q                  <= 4'h0;
         boot_done_q                 <= 1'b0;
         boot_pullup_en_q            <= 1'b1;
         internal_code_select_flag_q <= 1'b1;
      end else begin
         hold_cnt_q                  <= hold_cnt_d;
         boot_done_q                 <= boot_done_d;
         boot_pullup_en_q            <= boot_pullup_en_d;
         internal_code_select_flag_q <= internal_code_select_flag_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers, card power, card lines and read port.
   wire [N-1:0] pwr_sel_mask = ({{(N-1){1'b0}}, pwr_q[`GBSP_PWR_SEL_A]}
                                << `GBSP_PIN_PWR_A) |
                               ({{(N-1){1'b0}}, pwr_q[`GBSP_PWR_SEL_B]}
                                << `GBSP_PIN_PWR_B);
   wire [N-1:0] boot_mask = {{(N-1){1'b0}}, ~boot_done_q}
                            << `GBSP_PIN_BOOT;
   wire [N-1:0] pin_oe_d;
   wire [N-1:0] pin_out_d;
   reg  [N-1:0] rd_d;

   genvar p;
   generate
      for (p = 0; p < N; p = p + 1) begin : g_drv
         // Power pins while selected and the boot pin during strap stay released.
         assign pin_oe_d[p]  = dir_q[p] & ~pwr_sel_mask[p] &
                               ~boot_mask[p];
         assign pin_out_d[p] = out_q[p] & ~pwr_sel_mask[p];
      end
   endgenerate

   always @* begin
      case (reg_addr)
         `GBSP_REG_DIR:     rd_d = dir_q;
         `GBSP_REG_OUT:     rd_d = out_q;
         `GBSP_REG_IRQ_EN:  rd_d = irq_en_q;
         `GBSP_REG_EDGE:    rd_d = edge_q;
         `GBSP_REG_FLAG:    rd_d = flag;
         `GBSP_REG_IN:      rd_d = pin_s;
         `GBSP_REG_STAT1:   rd_d = {{(N-1){1'b0}},
                                    internal_code_select_flag_q};
         `GBSP_REG_PWRSEL:  rd_d = {{(N-4){1'b0}}, pwr_q};
         `GBSP_REG_CARDCTL: rd_d = {{(N-6){1'b0}}, card_s[1], cmd_in_q,
                                    cardctl_q};
         default:           rd_d = {N{1'b0}};
      endcase
   end

   // Read data stand for one cycle after each cycle with the read strobe high, and read as zero otherwise.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata_q <= {N{1'b0}};
      end else begin
         reg_rdata_q <= reg_rd ? rd_d : {N{1'b0}};
      end
   end

   // Pin drive enables and levels.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_oe_q  <= {N{1'b0}};
         pin_out_q <= {N{1'b0}};
      end else begin
         pin_oe_q  <= pin_oe_d;
         pin_out_q <= pin_out_d;
      end
   end

   // Interrupt line is the OR of all sticky flags.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_irq_q <= 1'b0;
      end else begin
         pin_irq_q <= |flag;
      end
   end

   // Card power follows the on bit only while its pin is selected.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         card_power_out_a_q <= 1'b0;
         card_power_out_b_q <= 1'b0;
      end else begin
         card_power_out_a_q <= pwr_q[`GBSP_PWR_SEL_A] &
                               pwr_q[`GBSP_PWR_ON_A];
         card_power_out_b_q <= pwr_q[`GBSP_PWR_SEL_B] &
                               pwr_q[`GBSP_PWR_ON_B];
      end
   end

   // Command line drive, pull-up and received level.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         card_command_line_out_q  <= 1'b0;
         card_command_line_oe_q   <= 1'b0;
         card_command_pullup_en_q <= 1'b1;
         cmd_in_q                 <= 1'b0;
      end else begin
         card_command_line_out_q  <= cardctl_q[`GBSP_CC_CMD_OUT];
         card_command_line_oe_q   <= cardctl_q[`GBSP_CC_CMD_OE];
         card_command_pullup_en_q <= cardctl_q[`GBSP_CC_CMD_PU];
         cmd_in_q                 <= card_s[0];
      end
   end

   // Write-protect pull-down and received level.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         card_write_protect_pd_en_q <= 1'b1;
         card_write_protect_q       <= 1'b0;
      end else begin
         card_write_protect_pd_en_q <= cardctl_q[`GBSP_CC_WP_PD];
         card_write_protect_q       <= card_s[1];
      end
   end
endmodule // gbsp_port
`default_nettype wire

// ---- bench/gbsp_port_monitor.sv ----
// Checker for the pin port: strap timing, register effects and pulls.
// Assumes it is bound into gbsp_port; one clock, async low reset.
`timescale 1ns/1ns
`default_nettype none
`include "gbsp_defs.vh"
module gbsp_port_monitor #(
   parameter N = 11
) (
   input wire logic         clk,
   input wire logic         arst_n,
   input wire logic [3:0]   reg_addr,
   input wire logic [N-1:0] reg_wdata,
   input wire logic         reg_wr,
   input wire logic         reg_rd,
   input wire logic [N-1:0] reg_rdata_q,
   input wire logic [N-1:0] pin_in,
   input wire logic [N-1:0] pin_oe_q,
   input wire logic         boot_pullup_en_q,
   input wire logic         internal_code_select_flag_q,
   input wire logic         pin_irq_q,
   input wire logic         card_power_out_a_q,
   input wire logic         card_write_protect_pd_en_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////
   property p_pu; $rose(arst_n) |-> boot_pullup_en_q[*8] ##1
      boot_pullup_en_q ##1 !boot_pullup_en_q; endproperty
   a_pu: assert property (p_pu) else $error("pull-up timing");
   property p_strap; $rose(arst_n) |->
      ##3 internal_code_select_flag_q == pin_in[`GBSP_PIN_BOOT]; endproperty
   a_strap: assert property (p_strap) else $error("strap level");
   property p_boot; boot_pullup_en_q |=> !pin_oe_q[`GBSP_PIN_BOOT];
   endproperty
   a_boot: assert property (p_boot) else $error("boot pin driven");
   property p_dir; reg_wr && reg_addr == `GBSP_REG_DIR |->
      ##2 pin_oe_q[0] == $past(reg_wdata[0], 2); endproperty
   a_dir: assert property (p_dir) else $error("direction");
   property p_pwr; reg_wr && reg_addr == `GBSP_REG_PWRSEL |-> ##2
      card_power_out_a_q == ($past(reg_wdata[2:0], 2) ==? 3'b1?1); endproperty
   a_pwr: assert property (p_pwr) else $error("card power");
   property p_wp; reg_wr && reg_addr == `GBSP_REG_CARDCTL |-> ##2
      card_write_protect_pd_en_q == $past(reg_wdata[1], 2); endproperty
   a_wp: assert property (p_wp) else $error("pull-down");
   property p_stat; reg_rd && reg_addr == `GBSP_REG_STAT1 |=>
      reg_rdata_q == N'(internal_code_select_flag_q); endproperty
   a_stat: assert property (p_stat) else $error("status read");
   property p_irq; $fell(pin_irq_q) |->
      $past(reg_wr && reg_addr == `GBSP_REG_FLAG, 2); endproperty
   a_irq: assert property (p_irq) else $error("flag not sticky");
endmodule // gbsp_port_monitor
bind gbsp_port gbsp_port_monitor #(.N(N)) i_gbsp_port_monitor (
   .clk                         (clk),
   .arst_n                      (arst_n),
   .reg_addr                    (reg_addr),
   .reg_wdata                   (reg_wdata),
   .reg_wr                      (reg_wr),
   .reg_rd                      (reg_rd),
   .reg_rdata_q                 (reg_rdata_q),
   .pin_in                      (pin_in),
   .pin_oe_q                    (pin_oe_q),
   .boot_pullup_en_q            (boot_pullup_en_q),
   .internal_code_select_flag_q (internal_code_select_flag_q),
   .pin_irq_q                   (pin_irq_q),
   .card_power_out_a_q          (card_power_out_a_q),
   .card_write_protect_pd_en_q  (card_write_protect_pd_en_q)
);
`default_nettype wire

// ---- bench/gbsp_pins_model.sv ----
// Far side of the pin port: buttons, LEDs, strap and card lines.
// Assumes undriven lines without a pull show a moving level.
`timescale 1ns/1ns
`default_nettype none
module gbsp_pins_model (
   input  wire logic        clk,
   input  wire logic [10:0] btn,
   input  wire logic [10:0] btn_en,
   input  wire logic        wp_ext,
   input  wire logic [10:0] pin_out_q,
   input  wire logic [10:0] pin_oe_q,
   input  wire logic        boot_pullup_en_q,
   input  wire logic        card_command_line_out_q,
   input  wire logic        card_command_line_oe_q,
   input  wire logic        card_command_pullup_en_q,
   input  wire logic        card_write_protect_pd_en_q,
   output var  logic [10:0] pin_in,
   output var  logic        card_command_line_in,
   output var  logic        card_write_protect_in
);
   logic tgl = 1'b0;
   always @(posedge clk) tgl <= ~tgl;
   always_comb begin
      pin_in = (pin_oe_q & pin_out_q) | (~pin_oe_q & btn_en & btn)
         | (~pin_oe_q & ~btn_en & {11{tgl}});
      if (!pin_oe_q[6] && !btn_en[6] && boot_pullup_en_q)
         pin_in[6] = 1'b1;
      card_command_line_in = card_command_line_oe_q ?
         card_command_line_out_q : card_command_pullup_en_q | tgl;
      card_write_protect_in = !card_write_protect_pd_en_q && wp_ext;
   end
endmodule // gbsp_pins_model
`default_nettype wire

// ---- bench/gbsp_port_tb.sv ----
// Bench for the pin port: strap, pins, power, edge flags, card lines.
// Assumes the far-side model resolves every level fed back in.
`timescale 1ns/1ns
`default_nettype none
`include "gbsp_defs.vh"
module gbsp_port_tb;
   logic        clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic        wp_ext = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [10:0] reg_wdata = 11'h000, btn = 11'h000, btn_en = 11'h7FF;
   wire  [10:0] reg_rdata_q, pin_in, pin_out_q, pin_oe_q;
   wire         boot_pullup_en_q, internal_code_select_flag_q, pin_irq_q;
   wire         card_power_out_a_q, card_power_out_b_q, card_command_line_in;
   wire         card_command_line_out_q, card_command_line_oe_q;
   wire         card_command_pullup_en_q, card_write_protect_in;
   wire         card_write_protect_pd_en_q, card_write_protect_q;
   wire  [15:0] pw = {3'h0, card_power_out_b_q, card_power_out_a_q, pin_oe_q};
   wire  [3:0]  cc = {card_command_line_out_q, card_command_line_oe_q,
                      card_command_pullup_en_q, card_write_protect_pd_en_q};
   int          n_mismatch = 0, cmp_count = 0;
   gbsp_port i_gbsp_port (
      .clk                         (clk),
      .arst_n                      (arst_n),
      .reg_addr                    (reg_addr),
      .reg_wdata                   (reg_wdata),
      .reg_wr                      (reg_wr),
      .reg_rd                      (reg_rd),
      .reg_rdata_q                 (reg_rdata_q),
      .pin_in                      (pin_in),
      .pin_out_q                   (pin_out_q),
      .pin_oe_q                    (pin_oe_q),
      .boot_pullup_en_q            (boot_pullup_en_q),
      .internal_code_select_flag_q (internal_code_select_flag_q),
      .pin_irq_q                   (pin_irq_q),
      .card_power_out_a_q          (card_power_out_a_q),
      .card_power_out_b_q          (card_power_out_b_q),
      .card_command_line_in        (card_command_line_in),
      .card_command_line_out_q     (card_command_line_out_q),
      .card_command_line_oe_q      (card_command_line_oe_q),
      .card_command_pullup_en_q    (card_command_pullup_en_q),
      .card_write_protect_in       (card_write_protect_in),
      .card_write_protect_pd_en_q  (card_write_protect_pd_en_q),
      .card_write_protect_q        (card_write_protect_q)
   );
   gbsp_pins_model i_gbsp_pins_model (
      .clk                         (clk),
      .btn                         (btn),
      .btn_en                      (btn_en),
      .wp_ext                      (wp_ext),
      .pin_out_q                   (pin_out_q),
      .pin_oe_q                    (pin_oe_q),
      .boot_pullup_en_q            (boot_pullup_en_q),
      .card_command_line_out_q     (card_command_line_out_q),
      .card_command_line_oe_q      (card_command_line_oe_q),
      .card_command_pullup_en_q    (card_command_pullup_en_q),
      .card_write_protect_pd_en_q  (card_write_protect_pd_en_q),
      .pin_in                      (pin_in),
      .card_command_line_in        (card_command_line_in),
      .card_write_protect_in       (card_write_protect_in)
   );
   always #5 clk = ~clk;
   ////////////////////////////
   task automatic chk(input logic [15:0] g, e);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic acc(input bit w, input logic [3:0] a, input logic [10:0] d);
      @(posedge clk);
      reg_wr    <= w;
      reg_rd    <= !w;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      #1 if (!w) chk({5'h00, reg_rdata_q}, {5'h00, d});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rst(input logic b);
      @(posedge clk);
      arst_n    <= 1'b0;
      btn[6]    <= b;
      btn_en[6] <= ~b;
      repeat (100) @(posedge clk);
      chk(16'(boot_pullup_en_q), 16'h0001);
      arst_n    <= 1'b1;
      acc(1, `GBSP_REG_DIR, 11'h040);
      cyc(6);
      chk(16'(boot_pullup_en_q), 16'h0001);
      chk(16'(pin_oe_q), 16'h0000);
      cyc(1);
      chk(16'(boot_pullup_en_q), 16'h0000);
      acc(0, `GBSP_REG_STAT1, {10'h000, b});
      chk(16'(pin_oe_q), 16'h0040);
   endtask
   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   ////////////////////////////
   initial begin
      #50000;
      n_mismatch++;
      end_sim;
   end
   initial begin
      rst(1'b0);
      rst(1'b1);
      acc(0, `GBSP_REG_CARDCTL, 11'h013);
      chk(16'(cc), 16'h0003);
      $display("test strap done");
      btn_en <= 11'h000;
      acc(1, `GBSP_REG_DIR, 11'h7FF);
      acc(1, `GBSP_REG_OUT, 11'h555);
      cyc(3);
      acc(0, `GBSP_REG_IN, 11'h555);
      acc(1, `GBSP_REG_PWRSEL, 11'h005);
      cyc(1);
      chk(pw, 16'h0EFF);
      chk(16'(pin_out_q), 16'h0455);
      acc(1, `GBSP_REG_PWRSEL, 11'h00A);
      cyc(1);
      chk(pw, 16'h13FF);
      acc(1, `GBSP_REG_PWRSEL, 11'h004);
      cyc(1);
      chk(pw, 16'h07FF);
      $display("test pins done");
      acc(1, `GBSP_REG_DIR, 11'h000);
      btn_en <= 11'h7FF;
      cyc(4);
      acc(1, `GBSP_REG_EDGE, 11'h002);
      acc(1, `GBSP_REG_IRQ_EN, 11'h006);
      btn[2:1] <= 2'b11;
      cyc(5);
      acc(0, `GBSP_REG_FLAG, 11'h002);
      chk(16'(pin_irq_q), 16'h0001);
      btn[2] <= 1'b0;
      cyc(5);
      acc(0, `GBSP_REG_FLAG, 11'h006);
      acc(1, `GBSP_REG_FLAG, 11'h002);
      acc(0, `GBSP_REG_FLAG, 11'h004);
      acc(1, `GBSP_REG_FLAG, 11'h004);
      cyc(2);
      chk(16'(pin_irq_q), 16'h0000);
      $display("test edges done");
      wp_ext <= 1'b1;
      acc(1, `GBSP_REG_CARDCTL, 11'h004);
      cyc(4);
      acc(0, `GBSP_REG_CARDCTL, 11'h024);
      chk(16'(card_write_protect_q), 16'h0001);
      acc(1, `GBSP_REG_CARDCTL, 11'h00C);
      cyc(4);
      chk(16'(cc), 16'h000C);
      acc(0, `GBSP_REG_CARDCTL, 11'h03C);
      acc(0, 4'hF, 11'h000);
      $display("test card done");
      end_sim;
   end
endmodule // gbsp_port_tb
`default_nettype wire
